// File: bench/dbgtrg_monitor.sv
// Assertion checker for the debug trigger block, bound to its top module.
`timescale 1ns/1ns
module dbgtrg_monitor (
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic [dbgtrg_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [dbgtrg_pkg::REG_DW-1:0]  reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    input  wire logic [dbgtrg_pkg::REG_DW-1:0]  reg_rdata,
    input  wire logic                           arm,
    input  wire dbgtrg_pkg::dbgtrg_cmp_s        cmp,
    input  wire logic                           exec_a,
    input  wire logic                           exec_b,
    input  wire logic                           tag_req_a,
    input  wire logic                           tag_req_b,
    input  wire logic                           trig_pulse,
    input  wire logic                           store_pulse,
    input  wire logic                           capture_on,
    input  wire logic                           begin_trace,
    input  wire logic                           run_done
);
    import dbgtrg_pkg::*;

    logic [7:0] shadow;
    logic [3:0] mode;
    logic       ev;

    // ------------------------------------------------------------
    // Expected control register contents.
    // ------------------------------------------------------------
    assign mode = shadow[MODE_HI:MODE_LO];
    assign ev   = (mode == MODE_EV_B) || (mode == MODE_A_EV_B);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shadow <= TRIG_CTRL_RST;
        end else if (reg_wr && !arm && reg_addr == OFS_TRIG_CTRL) begin
            shadow <= reg_wdata & WRITE_MASK;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RSV_ZERO: assert property ($past(reg_rd && reg_addr == OFS_TRIG_CTRL)
        |-> reg_rdata[BIT_RSV_HI:BIT_RSV_LO] == 2'b00)
        else $error("reserved bits read nonzero");
    AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == READ_ZERO)
        else $error("read data outside read slot");
    AST_RD_CTRL: assert property (reg_rd && reg_addr == OFS_TRIG_CTRL |=> reg_rdata == shadow)
        else $error("control readback wrong");
    AST_NO_TRIG_HI: assert property (mode > MODE_OUTSIDE |-> !trig_pulse && !store_pulse)
        else $error("trigger in a no-trigger mode");
    AST_HI_DONE: assert property (arm && $past(arm) && mode > MODE_OUTSIDE |-> ##[0:2] run_done)
        else $error("no-trigger run not done");
    AST_BEGIN_EFF: assert property (arm && $past(arm) |-> begin_trace == (shadow[BIT_BEGIN_SEL] || ev))
        else $error("effective begin mode wrong");
    AST_EV_NOCAP: assert property (arm && $past(arm) && ev |-> !capture_on)
        else $error("capture on in event mode");
    AST_STORE_EV: assert property (store_pulse |-> ev)
        else $error("store outside event mode");
    AST_FORCE_A: assert property (mode == MODE_A_ONLY && !shadow[BIT_TYPE_SEL] && trig_pulse
        |-> $past(cmp.a_addr_hit, 2))
        else $error("A-only trigger without A hit");
    AST_TAG_EXEC: assert property (shadow[BIT_TYPE_SEL] && trig_pulse
        |-> $past(exec_a, 2) || $past(exec_b, 2))
        else $error("tag trigger without execution");
    AST_TAG_REQ: assert property (tag_req_a || tag_req_b |-> shadow[BIT_TYPE_SEL] && $past(arm))
        else $error("tag request outside tag run");
    AST_END_CAP: assert property (trig_pulse && !begin_trace |-> !capture_on)
        else $error("end trace capture not stopped");

    cover property (arm && reg_wr);
    cover property (store_pulse);
    cover property (shadow[BIT_TYPE_SEL] && trig_pulse);
    cover property (tag_req_a || tag_req_b);
endmodule

bind dbgtrg_top dbgtrg_monitor u_monitor (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .arm, .cmp, .exec_a, .exec_b, .tag_req_a, .tag_req_b, .trig_pulse, .store_pulse, .capture_on,
    .begin_trace, .run_done);

// File: bench/test_debug_trigger_config.sv
// Self-checking testbench for the debug trigger block.
`timescale 1ns/1ns
module test_debug_trigger_config;
    import dbgtrg_pkg::*;

    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic [REG_AW-1:0]   reg_addr = '0;
    logic [REG_DW-1:0]   reg_wdata = '0;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [REG_DW-1:0]   reg_rdata;
    logic                arm = 1'b0;
    dbgtrg_cmp_s         cmp = '0;
    logic                exec_a = 1'b0;
    logic                exec_b = 1'b0;
    logic                tag_req_a;
    logic                tag_req_b;
    logic                trig_pulse;
    logic                store_pulse;
    logic                capture_on;
    logic                begin_trace;
    logic                run_done;
    int                  miscompares = 0;
    int                  total_checks = 0;

    always #2 clock = ~clock;

    dbgtrg_top u_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .arm, .cmp,
        .exec_a, .exec_b, .tag_req_a, .tag_req_b, .trig_pulse, .store_pulse, .capture_on,
        .begin_trace, .run_done);

    // ------------------------------------------------------------
    // Compare, bus and run tasks.
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chkn(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s count %0d exp %0d", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read data");
    endtask

    // Arms one run with control byte c, drives two hit cycles and counts the pulses.
    task automatic run(input logic [7:0] c, input logic [4:0] idle, input logic [4:0] h0,
                       input logic [4:0] h1, input logic ex, input int et, input int es);
        logic [7:0] nt;
        logic [7:0] ns;
        logic [7:0] nq;
        logic       ev;
        nt = 8'h00;
        ns = 8'h00;
        nq = 8'h00;
        ev = (c[3:0] == MODE_EV_B) || (c[3:0] == MODE_A_EV_B);
        wr(OFS_TRIG_CTRL, c);
        cmp <= idle;
        arm <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({7'h00, begin_trace}, {7'h00, c[6] | ev}, "begin trace");
        if (!c[6] && !ev && c[3:0] <= MODE_OUTSIDE) chk({7'h00, capture_on}, 8'h01, "end capture");
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            cmp <= (i == 0) ? h0 : (i == 1) ? h1 : idle;
            exec_a <= ex && (i == 2);
            exec_b <= ex && (i == 2);
            #1;
            nt = nt + {7'h00, trig_pulse};
            ns = ns + {7'h00, store_pulse};
            nq = nq + {7'h00, (tag_req_a | tag_req_b)};
        end
        chkn(nt, 8'(et), "trigger");
        chkn(ns, 8'(es), "store");
        if (c[7]) chkn(nq, 8'h01, "tag request");
        if (c[3:0] > MODE_OUTSIDE) chk({7'h00, run_done}, 8'h01, "done");
        if (!ev && c[3:0] <= MODE_OUTSIDE) begin
            chk({7'h00, capture_on}, {7'h00, c[6] == (et != 0)}, "capture after run");
        end
        @(posedge clock);
        arm <= 1'b0;
        cmp <= '0;
        repeat (2) @(posedge clock);
    endtask

    task automatic summarize;
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic test_regs;
        rd(OFS_TRIG_CTRL, TRIG_CTRL_RST);
        wr(OFS_TRIG_CTRL, 8'hff);
        rd(OFS_TRIG_CTRL, 8'hcf);
        rd(4'h5, READ_ZERO);
        wr(OFS_TRIG_CTRL, 8'h09);
        arm <= 1'b1;
        wr(OFS_TRIG_CTRL, 8'h80);
        rd(OFS_TRIG_CTRL, 8'h09);
        rd(OFS_TRIG_STAT, 8'h48);
        @(posedge clock);
        arm <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic test_modes;
        run(8'h00, 5'h00, 5'h10, 5'h00, 1'b0, 1, 0);
        run(8'h00, 5'h00, 5'h08, 5'h00, 1'b0, 0, 0);
        run(8'h01, 5'h00, 5'h08, 5'h00, 1'b0, 1, 0);
        run(8'h02, 5'h00, 5'h10, 5'h08, 1'b0, 1, 0);
        run(8'h02, 5'h00, 5'h08, 5'h10, 1'b0, 0, 0);
        run(8'h03, 5'h00, 5'h08, 5'h08, 1'b0, 0, 2);
        run(8'h04, 5'h00, 5'h10, 5'h08, 1'b0, 0, 1);
        run(8'h04, 5'h00, 5'h08, 5'h00, 1'b0, 0, 0);
        run(8'h05, 5'h00, 5'h14, 5'h00, 1'b0, 1, 0);
        run(8'h05, 5'h00, 5'h10, 5'h00, 1'b0, 0, 0);
        run(8'h06, 5'h00, 5'h10, 5'h00, 1'b0, 1, 0);
        run(8'h06, 5'h00, 5'h14, 5'h00, 1'b0, 0, 0);
        run(8'h07, 5'h00, 5'h00, 5'h00, 1'b0, 1, 0);
        run(8'h07, 5'h02, 5'h01, 5'h02, 1'b0, 0, 0);
        run(8'h08, 5'h00, 5'h02, 5'h00, 1'b0, 1, 0);
        run(8'h08, 5'h00, 5'h00, 5'h00, 1'b0, 0, 0);
        for (int m = 9; m < 16; m++) run({4'h0, 4'(m)}, 5'h1f, 5'h1f, 5'h1f, 1'b0, 0, 0);
        run(8'h43, 5'h00, 5'h08, 5'h00, 1'b0, 0, 1);
        run(8'h40, 5'h00, 5'h10, 5'h00, 1'b0, 1, 0);
        run(8'h80, 5'h00, 5'h10, 5'h00, 1'b0, 0, 0);
        run(8'h80, 5'h00, 5'h10, 5'h00, 1'b1, 1, 0);
        run(8'h81, 5'h00, 5'h08, 5'h00, 1'b1, 1, 0);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        test_regs();
        test_modes();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        summarize();
    end
endmodule

// File: design/dbgtrg_pkg.sv
// Constants, layouts and types shared by the debug trigger design.
package dbgtrg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          REG_AW         = 4;
    localparam int          REG_DW         = 8;
    localparam logic [3:0]  OFS_TRIG_CTRL  = 4'h0;
    localparam logic [3:0]  OFS_TRIG_STAT  = 4'h1;
    localparam logic [7:0]  TRIG_CTRL_RST  = 8'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;

    // ------------------------------------------------------------
    // Field positions of the trigger control register
    // ------------------------------------------------------------
    localparam int          BIT_TYPE_SEL   = 7;
    localparam int          BIT_BEGIN_SEL  = 6;
    localparam int          BIT_RSV_HI     = 5;
    localparam int          BIT_RSV_LO     = 4;
    localparam int          MODE_HI        = 3;
    localparam int          MODE_LO        = 0;
    localparam logic [7:0]  WRITE_MASK     = 8'hcf;

    // ------------------------------------------------------------
    // Trigger mode codes
    // ------------------------------------------------------------
    localparam logic [3:0]  MODE_A_ONLY    = 4'h0;
    localparam logic [3:0]  MODE_A_OR_B    = 4'h1;
    localparam logic [3:0]  MODE_A_THEN_B  = 4'h2;
    localparam logic [3:0]  MODE_EV_B      = 4'h3;
    localparam logic [3:0]  MODE_A_EV_B    = 4'h4;
    localparam logic [3:0]  MODE_A_AND_BD  = 4'h5;
    localparam logic [3:0]  MODE_A_NAND_BD = 4'h6;
    localparam logic [3:0]  MODE_INSIDE    = 4'h7;
    localparam logic [3:0]  MODE_OUTSIDE   = 4'h8;

    // ------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------
    localparam int          ST_TRIG_SEEN   = 0;
    localparam int          ST_CAPTURE     = 1;
    localparam int          ST_BEGIN       = 2;
    localparam int          ST_RUNNING     = 3;
    localparam int          ST_WAIT_B      = 4;
    localparam int          ST_EVENTS      = 5;
    localparam int          ST_DONE        = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       trigger_type_select;
        logic       begin_select;
        logic [1:0] rsv;
        logic [3:0] trigger_mode_field;
    } dbgtrg_ctrl_s;

    typedef struct packed {
        logic a_addr_hit;
        logic b_addr_hit;
        logic b_data_hit;
        logic addr_below_a;
        logic addr_above_b;
    } dbgtrg_cmp_s;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SEEK_A,
        S_SEEK_B,
        S_EVENTS,
        S_DONE
    } dbgtrg_state_e;

endpackage

// File: design/dbgtrg_qual.sv
// One comparator channel qualifier: force or opcode-executed tag path.
`timescale 1ns/1ns
module dbgtrg_qual #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         tag_mode,
    input  wire logic [W-1:0] raw_hit,
    input  wire logic [W-1:0] exec_hit,
    output logic      [W-1:0] hit
);
    import dbgtrg_pkg::*;

    // ------------------------------------------------------------
    // Qualified hit
    // ------------------------------------------------------------
    // force or tag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hit <= '0;
        end else if (tag_mode) begin
            hit <= exec_hit;
        end else begin
            hit <= raw_hit;
        end
    end
endmodule

// File: design/dbgtrg_regs.sv
// Trigger control register with write lock while armed.
`timescale 1ns/1ns
module dbgtrg_regs (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    wr_sel,
    input  wire logic                    armed,
    input  wire logic [7:0]              wdata,
    output dbgtrg_pkg::dbgtrg_ctrl_s     ctrl
);
    import dbgtrg_pkg::*;

    logic [7:0] next_ctrl;

    // ------------------------------------------------------------
    // Write data with hard-wired zero bits
    // ------------------------------------------------------------
    // reserved bits zero
    always_comb begin
        next_ctrl = wdata & WRITE_MASK;
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // write only disarmed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= TRIG_CTRL_RST;
        end else if (wr_sel && !armed) begin
            ctrl <= next_ctrl;
        end
    end
endmodule

// File: design/dbgtrg_top.sv
// Debug trigger control register and trigger formation logic.
// What this block does
// - Control register reads anytime; writes accepted only while disarmed.
// - Bits 4 and 5 read zero and ignore writes.
// - Type bit 7 clear triggers on access; set needs executed opcode.
// - Begin bit clear: capture until trigger; set: trigger starts capture.
// - Event-only modes ignore begin bit and act as begin traces.
// - Mode 0000 A only, 0001 A or B, 0010 A then B.
// - Mode 0011 stores on each B; 0100 waits A, then stores per B.
// - Mode 0101 A address and B data; 0110 A address, not B data.
// - Mode 0111 inside A..B inclusive; 1000 below A or above B.
// - Modes 1001 through 1111 never trigger.
`timescale 1ns/1ns
module dbgtrg_top (
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic [dbgtrg_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [dbgtrg_pkg::REG_DW-1:0]  reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [dbgtrg_pkg::REG_DW-1:0]  reg_rdata,
    input  wire logic                           arm,
    input  wire dbgtrg_pkg::dbgtrg_cmp_s        cmp,
    input  wire logic                           exec_a,
    input  wire logic                           exec_b,
    output logic                                tag_req_a,
    output logic                                tag_req_b,
    output logic                                trig_pulse,
    output logic                                store_pulse,
    output logic                                capture_on,
    output logic                                begin_trace,
    output logic                                run_done
);
    import dbgtrg_pkg::*;

    dbgtrg_ctrl_s  ctrl;
    dbgtrg_state_e state;
    dbgtrg_state_e next_state;
    logic          arm_q;
    logic          run_start;
    logic          running;
    logic          tag_mode;
    logic [3:0]    mode;
    logic          mode_valid;
    logic          event_only;
    logic          begin_eff;
    logic          in_range;
    logic          out_range;
    logic          raw_a;
    logic          raw_b;
    logic          hit_a;
    logic          hit_b;
    logic          fire;
    logic          store;
    logic          trig_seen;
    logic [7:0]    status;
    logic [7:0]    next_rdata;
    logic          wr_ctrl;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == OFS_TRIG_CTRL);
    dbgtrg_regs u_regs (
        .clock (clock),
        .rst   (rst),
        .wr_sel(wr_ctrl),
        .armed (arm),
        .wdata (reg_wdata),
        .ctrl  (ctrl)
    );

    // ------------------------------------------------------------
    // Configuration view
    // ------------------------------------------------------------
    assign tag_mode = ctrl.trigger_type_select;
    assign mode     = ctrl.trigger_mode_field;

    assign mode_valid = (mode <= MODE_OUTSIDE);
    assign event_only = (mode == MODE_EV_B) || (mode == MODE_A_EV_B);
    assign begin_eff  = event_only || ctrl.begin_select;

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arm_q <= 1'b0;
        end else begin
            arm_q <= arm;
        end
    end
    assign run_start = arm && !arm_q;
    assign running   = arm && arm_q;

    // ------------------------------------------------------------
    // Range comparisons
    // ------------------------------------------------------------
    // inclusive range
    assign in_range  = !cmp.addr_below_a && !cmp.addr_above_b;
    assign out_range = cmp.addr_below_a || cmp.addr_above_b;

    // ------------------------------------------------------------
    // Channel conditions per mode
    // ------------------------------------------------------------
    always_comb begin
        raw_a = 1'b0;
        raw_b = 1'b0;
        case (mode)
            MODE_A_ONLY: begin
                raw_a = cmp.a_addr_hit;
            end
            MODE_A_OR_B: begin
                raw_a = cmp.a_addr_hit;
                raw_b = cmp.b_addr_hit;
            end
            MODE_A_THEN_B: begin
                raw_a = cmp.a_addr_hit;
                raw_b = cmp.b_addr_hit;
            end
            MODE_EV_B: begin
                raw_b = cmp.b_addr_hit;
            end
            MODE_A_EV_B: begin
                raw_a = cmp.a_addr_hit;
                raw_b = cmp.b_addr_hit;
            end
            MODE_A_AND_BD: begin
                raw_a = cmp.a_addr_hit && cmp.b_data_hit;
            end
            MODE_A_NAND_BD: begin
                raw_a = cmp.a_addr_hit && !cmp.b_data_hit;
            end
            MODE_INSIDE: begin
                raw_a = in_range;
            end
            MODE_OUTSIDE: begin
                raw_a = out_range;
            end
            default: begin
                raw_a = 1'b0;
                raw_b = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Opcode tracking requests
    // ------------------------------------------------------------
    // tag requests out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tag_req_a <= 1'b0;
            tag_req_b <= 1'b0;
        end else begin
            tag_req_a <= tag_mode && running && raw_a;
            tag_req_b <= tag_mode && running && raw_b;
        end
    end

    // ------------------------------------------------------------
    // Qualified channels
    // ------------------------------------------------------------
    dbgtrg_qual #(
        .W(1)
    ) u_qual_a (
        .clock   (clock),
        .rst     (rst),
        .tag_mode(tag_mode),
        .raw_hit (running && raw_a),
        .exec_hit(running && exec_a),
        .hit     (hit_a)
    );
    dbgtrg_qual #(
        .W(1)
    ) u_qual_b (
        .clock   (clock),
        .rst     (rst),
        .tag_mode(tag_mode),
        .raw_hit (running && raw_b),
        .exec_hit(running && exec_b),
        .hit     (hit_b)
    );

    // ------------------------------------------------------------
    // Trigger sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        fire       = 1'b0;
        store      = 1'b0;
        case (state)
            S_IDLE: begin
                next_state = S_IDLE;
            end
            S_SEEK_A: begin
                case (mode)
                    MODE_A_OR_B: begin
                        fire = hit_a || hit_b;
                    end
                    MODE_A_THEN_B: begin
                        if (hit_a) begin
                            next_state = S_SEEK_B;
                        end
                    end
                    MODE_A_EV_B: begin
                        if (hit_a) begin
                            next_state = S_EVENTS;
                        end
                    end
                    default: begin
                        fire = hit_a && mode_valid;
                    end
                endcase
                if (fire) begin
                    next_state = S_DONE;
                end
            end
            S_SEEK_B: begin
                fire = hit_b;
                if (fire) begin
                    next_state = S_DONE;
                end
            end
            S_EVENTS: begin
                store = hit_b;
            end
            S_DONE: begin
                next_state = S_DONE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (run_start) begin
            fire  = 1'b0;
            store = 1'b0;
            if (!mode_valid) begin
                next_state = S_DONE;
            end else if (mode == MODE_EV_B) begin
                next_state = S_EVENTS;
            end else begin
                next_state = S_SEEK_A;
            end
        end
        if (!arm) begin
            fire       = 1'b0;
            store      = 1'b0;
            next_state = S_IDLE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_pulse  <= 1'b0;
            store_pulse <= 1'b0;
        end else begin
            trig_pulse  <= fire;
            store_pulse <= store;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_seen <= 1'b0;
        end else if (run_start) begin
            trig_seen <= 1'b0;
        end else if (fire) begin
            trig_seen <= 1'b1;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_done <= 1'b0;
        end else begin
            run_done <= (next_state == S_DONE);
        end
    end

    // ------------------------------------------------------------
    // Capture window
    // ------------------------------------------------------------
    // begin or end trace
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_on <= 1'b0;
        end else if (!arm) begin
            capture_on <= 1'b0;
        end else if (run_start) begin
            capture_on <= !begin_eff && mode_valid;
        end else if (fire) begin
            capture_on <= begin_eff;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            begin_trace <= 1'b0;
        end else begin
            begin_trace <= begin_eff;
        end
    end

    // ------------------------------------------------------------
    // Status and read port
    // ------------------------------------------------------------
    always_comb begin
        status               = READ_ZERO;
        status[ST_TRIG_SEEN] = trig_seen;
        status[ST_CAPTURE]   = capture_on;
        status[ST_BEGIN]     = begin_trace;
        status[ST_RUNNING]   = arm;
        status[ST_WAIT_B]    = (state == S_SEEK_B);
        status[ST_EVENTS]    = (state == S_EVENTS);
        status[ST_DONE]      = (state == S_DONE);
    end

    always_comb begin
        next_rdata = READ_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                OFS_TRIG_CTRL: begin
                    next_rdata = ctrl;
                end
                OFS_TRIG_STAT: begin
                    next_rdata = status;
                end
                default: begin
                    next_rdata = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule
